// ---- rtl/port_bcd_alt_function_override.sv ----
// Alternate function override for ports B, C and D.
// Peripherals and port registers are in the core clock domain; pad
// inputs are taken as synchronous. Pad controls and peripheral inputs
// are registered, so they trail their causes by one clock; the filtered SDA input trails by four.
`timescale 1ns/1ps
`include "port_bcd_consts.svh"

module port_bcd_alt_function_override (
    input  wire logic                   core_clk_i,
    input  wire logic                   reset_i,
    // Port registers and pads
    input  wire port_bcd_pkg::pin_vec_t portb_dir_i,
    input  wire port_bcd_pkg::pin_vec_t portb_out_i,
    input  wire port_bcd_pkg::pin_vec_t portb_pin_i,
    input  wire port_bcd_pkg::pin_vec_t portc_dir_i,
    input  wire port_bcd_pkg::pin_vec_t portc_out_i,
    input  wire port_bcd_pkg::pin_vec_t portd_dir_i,
    input  wire port_bcd_pkg::pin_vec_t portd_out_i,
    input  wire port_bcd_pkg::pin_vec_t portd_pin_i,
    input  wire logic                   pullup_global_off_i,
    input  wire logic                   inbuf_default_i,
    output port_bcd_pkg::pin_vec_t      portb_drive_n_o,
    output port_bcd_pkg::pin_vec_t      portb_value_o,
    output port_bcd_pkg::pin_vec_t      portb_pullup_o,
    output port_bcd_pkg::pin_vec_t      portb_inbuf_en_o,
    output port_bcd_pkg::pin_vec_t      portc_drive_n_o,
    output port_bcd_pkg::pin_vec_t      portc_value_o,
    output port_bcd_pkg::pin_vec_t      portc_pullup_o,
    output port_bcd_pkg::pin_vec_t      portc_inbuf_en_o,
    output port_bcd_pkg::pin_vec_t      portd_drive_n_o,
    output port_bcd_pkg::pin_vec_t      portd_value_o,
    output port_bcd_pkg::pin_vec_t      portd_pullup_o,
    output port_bcd_pkg::pin_vec_t      portd_inbuf_en_o,
    // Timers
    input  wire logic                   t0_cmpa_out_en_i,
    input  wire logic                   t0_cmpa_out_i,
    input  wire logic                   t1_cmpa_out_en_i,
    input  wire logic                   t1_cmpa_out_i,
    input  wire logic                   t1_cmpb_out_en_i,
    input  wire logic                   t1_cmpb_out_i,
    input  wire logic                   t1_cmpc_out_en_i,
    input  wire logic                   t1_cmpc_out_i,
    input  wire logic                   t2_cmpa_out_en_i,
    input  wire logic                   t2_cmpa_out_i,
    output logic                        t0_ext_clk_in_o,
    output logic                        t1_ext_clk_in_o,
    output logic                        t1_capture_in_o,
    // Pin change
    input  wire logic                   pinchg_group0_en_i,
    input  wire port_bcd_pkg::pin_vec_t pinchg_mask_i,
    output port_bcd_pkg::pin_vec_t      pinchg_src_o,
    // SPI
    input  wire logic                   spi_on_i,
    input  wire logic                   spi_master_sel_i,
    input  wire logic                   spi_slave_out_i,
    input  wire logic                   spi_master_out_i,
    input  wire logic                   spi_sck_out_i,
    output logic                        spi_master_in_o,
    output logic                        spi_slave_in_o,
    output logic                        spi_sck_in_o,
    output logic                        spi_slave_active_o,
    // External memory
    input  wire logic                   extmem_on_i,
    input  wire port_bcd_pkg::himask_t  extmem_high_mask_i,
    input  wire port_bcd_pkg::pin_vec_t extmem_addr_high_i,
    // USART1
    input  wire logic                   usart1_sync_mode_i,
    input  wire logic                   usart1_xclk_out_i,
    output logic                        usart1_xclk_in_o,
    input  wire logic                   usart1_tx_en_i,
    input  wire logic                   usart1_tx_i,
    input  wire logic                   usart1_rx_en_i,
    output logic                        usart1_rx_o,
    // External interrupts
    input  wire logic [3:0]             ext_irq_en_i,
    output logic [3:0]                  ext_irq_o,
    // Two-wire data
    input  wire logic                   twi_on_i,
    input  wire logic                   twi_sda_pull_low_i,
    output logic                        twi_sda_in_o
);
    pin_ovr_if ovr_b ();
    pin_ovr_if ovr_c ();
    pin_ovr_if ovr_d ();

    port_bcd_pkg::pin_vec_t next_b_drive_n, next_b_value, next_b_pullup, next_b_inbuf;
    port_bcd_pkg::pin_vec_t next_c_drive_n, next_c_value, next_c_pullup, next_c_inbuf;
    port_bcd_pkg::pin_vec_t next_d_drive_n, next_d_value, next_d_pullup, next_d_inbuf;
    port_bcd_pkg::pin_vec_t extmem_take;
    port_bcd_pkg::pin_vec_t pullup_ok;
    logic                   spi_master;
    logic                   spi_slave;
    logic                   sda_clean;
    logic                   xclk_drive;

    assign pullup_ok  = {`PORT_W{~pullup_global_off_i}};
    assign spi_master = spi_on_i & spi_master_sel_i;
    assign spi_slave  = spi_on_i & ~spi_master_sel_i;

    // Port B: timers on the top nibble, SPI on the bottom
    // Timer0 wins PB7 when both timers claim it
    assign ovr_b.value_override_en = {t0_cmpa_out_en_i | t1_cmpc_out_en_i, t1_cmpb_out_en_i,
                                      t1_cmpa_out_en_i, t2_cmpa_out_en_i,
                                      spi_slave, spi_master, spi_master, 1'h0};
    assign ovr_b.value_override_val = {t0_cmpa_out_en_i ? t0_cmpa_out_i : t1_cmpc_out_i,
                                       t1_cmpb_out_i, t1_cmpa_out_i, t2_cmpa_out_i,
                                       spi_slave_out_i, spi_master_out_i, spi_sck_out_i, 1'h0};
    // Direction of compare pins stays with the direction register
    assign ovr_b.dir_override_en  = {4'h0, spi_master, {3{spi_slave}}};
    assign ovr_b.dir_override_val = 8'h00;
    assign ovr_b.pullup_override_en  = {4'h0, spi_master, {3{spi_slave}}};
    assign ovr_b.pullup_override_val = {4'h0, portb_out_i[3:0] & pullup_ok[3:0]};
    assign ovr_b.inbuf_override_en  = pinchg_mask_i & {`PORT_W{pinchg_group0_en_i}};
    assign ovr_b.inbuf_override_val = 8'hff;

    // Port C: high address byte
    // Mask widened by one bit to match the 4-bit threshold, which is at most 7
    genvar k;
    generate
        for (k = 0; k < `PORT_W; k++) begin : g_himask
            localparam int THR = (k >= 2) ? (`HIMASK_THR_BASE - k) : `HIMASK_THR_FLOOR;
            assign extmem_take[k] = extmem_on_i & ({1'h0, extmem_high_mask_i} < 4'(THR));
        end
    endgenerate

    assign ovr_c.pullup_override_en  = extmem_take;
    assign ovr_c.pullup_override_val = 8'h00;
    assign ovr_c.dir_override_en     = extmem_take;
    assign ovr_c.dir_override_val    = 8'hff;
    assign ovr_c.value_override_en   = extmem_take;
    assign ovr_c.value_override_val  = extmem_addr_high_i;
    assign ovr_c.inbuf_override_en   = 8'h00;
    assign ovr_c.inbuf_override_val  = 8'h00;

    // Port D: PD7, PD6 and PD4 are pure inputs to the timers
    assign xclk_drive = usart1_sync_mode_i & portd_dir_i[`USART1_XCLK_BIT];

    assign ovr_d.pullup_override_en  = {4'h0, usart1_tx_en_i, usart1_rx_en_i, twi_on_i, 1'h0};
    assign ovr_d.pullup_override_val = {5'h00, portd_out_i[2:1] & pullup_ok[2:1], 1'h0};
    assign ovr_d.dir_override_en     = {4'h0, usart1_tx_en_i, usart1_rx_en_i, twi_on_i, 1'h0};
    // Open drain: only a low is ever driven on the data line
    assign ovr_d.dir_override_val    = {4'h0, 1'h1, 1'h0, twi_sda_pull_low_i, 1'h0};
    assign ovr_d.value_override_en   = {2'h0, xclk_drive, 1'h0, usart1_tx_en_i, 1'h0, twi_on_i, 1'h0};
    assign ovr_d.value_override_val  = {2'h0, usart1_xclk_out_i, 1'h0, usart1_tx_i, 3'h0};
    assign ovr_d.inbuf_override_en   = {4'h0, ext_irq_en_i};
    assign ovr_d.inbuf_override_val  = 8'h0f;

    pin_ovr_cell u_cell_b (
        .ovr                 (ovr_b.res),
        .dir_i               (portb_dir_i),
        .out_i               (portb_out_i),
        .pullup_global_off_i (pullup_global_off_i),
        .inbuf_default_i     (inbuf_default_i),
        .drive_n_o           (next_b_drive_n),
        .value_o             (next_b_value),
        .pullup_o            (next_b_pullup),
        .inbuf_en_o          (next_b_inbuf)
    );

    pin_ovr_cell u_cell_c (
        .ovr                 (ovr_c.res),
        .dir_i               (portc_dir_i),
        .out_i               (portc_out_i),
        .pullup_global_off_i (pullup_global_off_i),
        .inbuf_default_i     (inbuf_default_i),
        .drive_n_o           (next_c_drive_n),
        .value_o             (next_c_value),
        .pullup_o            (next_c_pullup),
        .inbuf_en_o          (next_c_inbuf)
    );

    pin_ovr_cell u_cell_d (
        .ovr                 (ovr_d.res),
        .dir_i               (portd_dir_i),
        .out_i               (portd_out_i),
        .pullup_global_off_i (pullup_global_off_i),
        .inbuf_default_i     (inbuf_default_i),
        .drive_n_o           (next_d_drive_n),
        .value_o             (next_d_value),
        .pullup_o            (next_d_pullup),
        .inbuf_en_o          (next_d_inbuf)
    );

    twi_spike_filter u_sda_filter (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .raw_i      (portd_pin_i[`TWI_SDA_BIT]),
        .clean_o    (sda_clean)
    );

    // Pads: all drivers off and pull-ups off during reset
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            portb_drive_n_o  <= `PAD_DRIVE_N_RST;
            portb_value_o    <= `PAD_VAL_RST;
            portb_pullup_o   <= `PAD_PULLUP_RST;
            portb_inbuf_en_o <= `PAD_INBUF_RST;
        end else begin
            portb_drive_n_o  <= next_b_drive_n;
            portb_value_o    <= next_b_value;
            portb_pullup_o   <= next_b_pullup;
            portb_inbuf_en_o <= next_b_inbuf;
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            portc_drive_n_o  <= `PAD_DRIVE_N_RST;
            portc_value_o    <= `PAD_VAL_RST;
            portc_pullup_o   <= `PAD_PULLUP_RST;
            portc_inbuf_en_o <= `PAD_INBUF_RST;
        end else begin
            portc_drive_n_o  <= next_c_drive_n;
            portc_value_o    <= next_c_value;
            portc_pullup_o   <= next_c_pullup;
            portc_inbuf_en_o <= next_c_inbuf;
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            portd_drive_n_o  <= `PAD_DRIVE_N_RST;
            portd_value_o    <= `PAD_VAL_RST;
            portd_pullup_o   <= `PAD_PULLUP_RST;
            portd_inbuf_en_o <= `PAD_INBUF_RST;
        end else begin
            portd_drive_n_o  <= next_d_drive_n;
            portd_value_o    <= next_d_value;
            portd_pullup_o   <= next_d_pullup;
            portd_inbuf_en_o <= next_d_inbuf;
        end
    end

    // Inputs to the peripherals
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            pinchg_src_o <= `PAD_VAL_RST;
            ext_irq_o    <= 4'h0;
        end else begin
            pinchg_src_o <= portb_pin_i;
            ext_irq_o    <= portd_pin_i[3:0];
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            spi_master_in_o    <= 1'h0;
            spi_slave_in_o     <= 1'h0;
            spi_sck_in_o       <= 1'h0;
            spi_slave_active_o <= 1'h0;
        end else begin
            spi_master_in_o    <= portb_pin_i[`SPI_MISO_BIT];
            spi_slave_in_o     <= portb_pin_i[`SPI_MOSI_BIT];
            spi_sck_in_o       <= portb_pin_i[`SPI_SCK_BIT];
            spi_slave_active_o <= spi_slave & ~portb_pin_i[`SPI_SS_BIT];
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            t0_ext_clk_in_o  <= 1'h0;
            t1_ext_clk_in_o  <= 1'h0;
            t1_capture_in_o  <= 1'h0;
            usart1_xclk_in_o <= 1'h0;
            usart1_rx_o      <= `LINE_IDLE_RST;
            twi_sda_in_o     <= `LINE_IDLE_RST;
        end else begin
            t0_ext_clk_in_o  <= portd_pin_i[`T0_CLK_BIT];
            t1_ext_clk_in_o  <= portd_pin_i[`T1_CLK_BIT];
            t1_capture_in_o  <= portd_pin_i[`T1_CAPT_BIT];
            // Clock input is quiet outside synchronous mode
            usart1_xclk_in_o <= usart1_sync_mode_i & portd_pin_i[`USART1_XCLK_BIT];
            usart1_rx_o      <= portd_pin_i[`USART1_RX_BIT];
            twi_sda_in_o     <= sda_clean;
        end
    end
endmodule : port_bcd_alt_function_override

// ---- rtl/port_bcd_consts.svh ----
// Constants for the port B/C/D alternate function override block.
// Assumes a 50 MHz core clock; included by bare name.
`ifndef PORT_BCD_CONSTS_SVH
`define PORT_BCD_CONSTS_SVH

`define CLK_PERIOD_NS      20
`define TWI_SPIKE_NS       50
// Least time, rounded up to whole cycles
`define TWI_SPIKE_CYC      ((`TWI_SPIKE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TWI_SPIKE_CNT_W    2

`define PORT_W             8
`define PAD_VAL_RST        8'h00
`define PAD_DRIVE_N_RST    8'hff
`define PAD_PULLUP_RST     8'h00
`define PAD_INBUF_RST      8'h00
`define LINE_IDLE_RST      1'h1

// Port C takeover threshold: 8 - bit for bits 7..2, floor 7 for bits 1..0
`define HIMASK_THR_BASE    8
`define HIMASK_THR_FLOOR   7
`define HIMASK_W           3

`define SPI_MISO_BIT       3
`define SPI_MOSI_BIT       2
`define SPI_SCK_BIT        1
`define SPI_SS_BIT         0
`define TWI_SDA_BIT        1
`define USART1_TX_BIT      3
`define USART1_RX_BIT      2
`define USART1_XCLK_BIT    5
`define T0_CLK_BIT         7
`define T1_CLK_BIT         6
`define T1_CAPT_BIT        4

`endif

// ---- rtl/port_bcd_pkg.sv ----
// Types shared by the port B/C/D override block.
// Assumes port_bcd_consts.svh is on the include path.
`include "port_bcd_consts.svh"

package port_bcd_pkg;
    typedef logic [`PORT_W-1:0] pin_vec_t;
    typedef logic [`HIMASK_W-1:0] himask_t;
endpackage : port_bcd_pkg

// ---- rtl/pin_ovr_if.sv ----
// Override signal bundle for one 8-pin port.
// Driven by the top module, resolved by pin_ovr_cell.
`timescale 1ns/1ps

interface pin_ovr_if;
    port_bcd_pkg::pin_vec_t pullup_override_en;
    port_bcd_pkg::pin_vec_t pullup_override_val;
    port_bcd_pkg::pin_vec_t dir_override_en;
    port_bcd_pkg::pin_vec_t dir_override_val;
    port_bcd_pkg::pin_vec_t value_override_en;
    port_bcd_pkg::pin_vec_t value_override_val;
    port_bcd_pkg::pin_vec_t inbuf_override_en;
    port_bcd_pkg::pin_vec_t inbuf_override_val;

    modport src (
        output pullup_override_en, pullup_override_val, dir_override_en, dir_override_val,
        output value_override_en, value_override_val, inbuf_override_en, inbuf_override_val
    );
    modport res (
        input pullup_override_en, pullup_override_val, dir_override_en, dir_override_val,
        input value_override_en, value_override_val, inbuf_override_en, inbuf_override_val
    );
endinterface : pin_ovr_if

// ---- rtl/pin_ovr_cell.sv ----
// Combinational resolution of override signals for one 8-pin port.
// Port register bits come in synchronous to the core clock.
`timescale 1ns/1ps
`include "port_bcd_consts.svh"

module pin_ovr_cell (
    pin_ovr_if.res                 ovr,
    input  wire port_bcd_pkg::pin_vec_t dir_i,
    input  wire port_bcd_pkg::pin_vec_t out_i,
    input  wire logic              pullup_global_off_i,
    input  wire logic              inbuf_default_i,
    output port_bcd_pkg::pin_vec_t drive_n_o,
    output port_bcd_pkg::pin_vec_t value_o,
    output port_bcd_pkg::pin_vec_t pullup_o,
    output port_bcd_pkg::pin_vec_t inbuf_en_o
);
    genvar i;
    generate
        for (i = 0; i < `PORT_W; i++) begin : g_pin
            logic drive;
            assign drive = ovr.dir_override_en[i] ? ovr.dir_override_val[i] : dir_i[i];
            assign drive_n_o[i] = ~drive;
            assign value_o[i] = ovr.value_override_en[i] ? ovr.value_override_val[i] : out_i[i];
            // Default pull-up only for an input with its output bit high
            assign pullup_o[i] = ovr.pullup_override_en[i] ? ovr.pullup_override_val[i]
                               : (~dir_i[i] & out_i[i] & ~pullup_global_off_i);
            assign inbuf_en_o[i] = ovr.inbuf_override_en[i] ? ovr.inbuf_override_val[i]
                                 : inbuf_default_i;
        end
    endgenerate
endmodule : pin_ovr_cell

// ---- rtl/twi_spike_filter.sv ----
// Spike filter for the two-wire data input.
// A level is accepted only after it has stood for the filter time.
`timescale 1ns/1ps
`include "port_bcd_consts.svh"

module twi_spike_filter (
    input  wire logic core_clk_i,
    input  wire logic reset_i,
    input  wire logic raw_i,
    output logic      clean_o
);
    logic [`TWI_SPIKE_CNT_W-1:0] stable_cnt;
    localparam logic [`TWI_SPIKE_CNT_W-1:0] SPIKE_LAST = `TWI_SPIKE_CNT_W'(`TWI_SPIKE_CYC - 1);

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            stable_cnt <= '0;
        end else if (raw_i == clean_o || stable_cnt == SPIKE_LAST) begin
            stable_cnt <= '0;
        end else begin
            stable_cnt <= stable_cnt + 1'h1;
        end
    end

    // Shorter pulses restart the count and never reach the output
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            clean_o <= `LINE_IDLE_RST;
        end else if (raw_i != clean_o && stable_cnt == SPIKE_LAST) begin
            clean_o <= raw_i;
        end
    end
endmodule : twi_spike_filter

// ---- testbench/port_bcd_override_monitor.sv ----
// Checker for the port B/C/D override block, bound to its top module.
// Assumes every output but the filtered SDA input trails its cause by exactly one core clock.
`timescale 1ns/1ps
module port_bcd_override_checker (
    input logic       core_clk_i,
    input logic       reset_i,
    input logic [7:0] portb_dir_i,
    input logic [7:0] portb_out_i,
    input logic [7:0] portc_dir_i,
    input logic [7:0] portd_out_i,
    input logic [7:0] portd_pin_i,
    input logic       pullup_global_off_i,
    input logic [7:0] portb_drive_n_o,
    input logic [7:0] portb_value_o,
    input logic [7:0] portb_pullup_o,
    input logic [7:0] portc_drive_n_o,
    input logic [7:0] portc_value_o,
    input logic [7:0] portd_drive_n_o,
    input logic [7:0] portd_value_o,
    input logic [7:0] portd_pullup_o,
    input logic       t2_cmpa_out_en_i,
    input logic       t2_cmpa_out_i,
    input logic       spi_on_i,
    input logic       spi_master_sel_i,
    input logic       extmem_on_i,
    input logic [2:0] extmem_high_mask_i,
    input logic [7:0] extmem_addr_high_i,
    input logic       usart1_tx_en_i,
    input logic       usart1_tx_i,
    input logic       usart1_rx_en_i,
    input logic       t1_capture_in_o,
    input logic [3:0] ext_irq_o,
    input logic       twi_sda_in_o
);
    logic       just_reset;
    logic [7:0] take;
    // First edge after release still shows reset values
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) just_reset <= 1'b1;
        else just_reset <= 1'b0;
    end
    always_comb begin
        for (int i = 0; i < 8; i++) take[i] = extmem_on_i && (extmem_high_mask_i < ((i > 1) ? 8 - i : 7));
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i || just_reset);
    AST_T2_PB4: assert property ($past(t2_cmpa_out_en_i) |-> portb_value_o[4] == $past(t2_cmpa_out_i)
        && portb_drive_n_o[4] == $past(!portb_dir_i[4])) else $error("timer2 pin wrong");
    AST_MISO_IN: assert property ($past(spi_on_i && spi_master_sel_i) |-> portb_drive_n_o[3]
        && portb_pullup_o[3] == $past(portb_out_i[3] && !pullup_global_off_i)) else $error("miso not input");
    AST_SLAVE_IN: assert property ($past(spi_on_i && !spi_master_sel_i) |-> portb_drive_n_o[2:0] == 3'h7)
        else $error("slave pins driven");
    AST_PC_TAKE: assert property ($past(|take) |-> portc_drive_n_o == $past(~(take | portc_dir_i))
        && (portc_value_o & $past(take)) == $past(extmem_addr_high_i & take)) else $error("address pins wrong");
    AST_TX_OUT: assert property ($past(usart1_tx_en_i) |-> !portd_drive_n_o[3]
        && portd_value_o[3] == $past(usart1_tx_i)) else $error("tx pin wrong");
    AST_RX_IN: assert property ($past(usart1_rx_en_i) |-> portd_drive_n_o[2]
        && portd_pullup_o[2] == $past(portd_out_i[2] && !pullup_global_off_i)) else $error("rx pin wrong");
    AST_PD_FEED: assert property ($changed(portd_pin_i) |=>
        {t1_capture_in_o, ext_irq_o} == $past({portd_pin_i[4], portd_pin_i[3:0]})) else $error("pd feed wrong");
    AST_SDA_SPIKE: assert property ($changed(twi_sda_in_o) |-> $past(portd_pin_i[1], 2) == twi_sda_in_o
        && $past(portd_pin_i[1], 3) == twi_sda_in_o) else $error("sda spike passed");
    CVR_SPI_MASTER: cover property (spi_on_i && spi_master_sel_i);
    CVR_HIMASK_ALL: cover property (extmem_on_i && extmem_high_mask_i == 3'h0);
    CVR_SDA_FALL: cover property ($fell(twi_sda_in_o));
endmodule : port_bcd_override_checker

bind port_bcd_alt_function_override port_bcd_override_checker chk (.*);

// ---- testbench/periph_model.sv ----
// Peripheral side: compare, SPI, USART transmit and clock outputs.
// Changes on the falling edge, so the block samples settled values.
`timescale 1ns/1ps
module periph_model (
    input  wire logic core_clk_i,
    input  wire logic reset_i,
    output logic [9:0] wave_o
);
    // Odd step keeps every bit toggling at its own rate, like PWM
    always_ff @(negedge core_clk_i or posedge reset_i) begin
        if (reset_i) wave_o <= 10'h000;
        else wave_o <= wave_o + 10'h0b5;
    end
endmodule : periph_model

// ---- testbench/port_bcd_alt_function_override_tb_top.sv ----
// Self-checking bench for the port B/C/D override block.
// Inputs change on the falling edge; outputs are read just after the rising edge.
`timescale 1ns/1ps
module port_bcd_alt_function_override_tb_top;
    logic core_clk_i = 1'b0, reset_i = 1'b1, pullup_global_off_i = 1'b0, inbuf_default_i = 1'b0;
    port_bcd_pkg::pin_vec_t portb_dir_i, portb_out_i, portb_pin_i, portc_dir_i, portc_out_i, portd_dir_i, tk;
    port_bcd_pkg::pin_vec_t portd_out_i, portd_pin_i, pinchg_mask_i, extmem_addr_high_i, pinchg_src_o;
    port_bcd_pkg::pin_vec_t portb_drive_n_o, portb_value_o, portb_pullup_o, portb_inbuf_en_o, portc_drive_n_o;
    port_bcd_pkg::pin_vec_t portc_value_o, portc_pullup_o, portc_inbuf_en_o, portd_drive_n_o, portd_value_o;
    port_bcd_pkg::pin_vec_t portd_pullup_o, portd_inbuf_en_o;
    logic t0_cmpa_out_en_i, t0_cmpa_out_i, t1_cmpa_out_en_i, t1_cmpa_out_i, t1_cmpb_out_en_i, t1_cmpb_out_i;
    logic t1_cmpc_out_en_i, t1_cmpc_out_i, t2_cmpa_out_en_i, t2_cmpa_out_i, t0_ext_clk_in_o, t1_ext_clk_in_o;
    logic t1_capture_in_o, pinchg_group0_en_i, spi_on_i, spi_master_sel_i, spi_slave_out_i, spi_master_out_i;
    logic spi_sck_out_i, spi_master_in_o, spi_slave_in_o, spi_sck_in_o, spi_slave_active_o, extmem_on_i;
    logic usart1_sync_mode_i, usart1_xclk_out_i, usart1_xclk_in_o, usart1_tx_en_i, usart1_tx_i, usart1_rx_en_i;
    logic usart1_rx_o, twi_on_i, twi_sda_pull_low_i, twi_sda_in_o;
    logic [3:0] ext_irq_en_i, ext_irq_o;
    logic [9:0] wave;
    port_bcd_pkg::himask_t extmem_high_mask_i;
    int fails = 0, samples_checked = 0;
    assign {t0_cmpa_out_i, t1_cmpa_out_i, t1_cmpb_out_i, t1_cmpc_out_i, t2_cmpa_out_i} = wave[9:5];
    assign {spi_slave_out_i, spi_master_out_i, spi_sck_out_i, usart1_tx_i, usart1_xclk_out_i} = wave[4:0];
    periph_model pm (.core_clk_i(core_clk_i), .reset_i(reset_i), .wave_o(wave));
    port_bcd_alt_function_override dut (.*);
    always #10 core_clk_i = ~core_clk_i;
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tick();
        @(posedge core_clk_i);
        #1;
    endtask : tick
    task automatic complete_run();
        $display("fails %0d samples_checked %0d", fails, samples_checked);
        if (fails == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run
    initial begin
        {portb_dir_i, portb_out_i, portc_dir_i, portc_out_i, portd_dir_i, portd_out_i} = '0;
        {portb_pin_i, portd_pin_i, pinchg_mask_i, extmem_addr_high_i} = 32'h00ff0000;
        {t0_cmpa_out_en_i, t1_cmpa_out_en_i, t1_cmpb_out_en_i, t1_cmpc_out_en_i, t2_cmpa_out_en_i} = '0;
        {pinchg_group0_en_i, spi_on_i, spi_master_sel_i, extmem_on_i, usart1_sync_mode_i} = '0;
        {usart1_tx_en_i, usart1_rx_en_i, twi_on_i, twi_sda_pull_low_i, ext_irq_en_i, extmem_high_mask_i} = '0;
        repeat (16) tick();
        check("rst_drv", portb_drive_n_o & portc_drive_n_o & portd_drive_n_o, 8'hff);
        check("rst_misc", {portb_value_o[0], portd_pullup_o[0], usart1_rx_o, twi_sda_in_o, ext_irq_o}, 8'h30);
        @(negedge core_clk_i);
        reset_i = 1'b0;
        {portb_dir_i, t0_cmpa_out_en_i, t1_cmpa_out_en_i, t1_cmpb_out_en_i, t1_cmpc_out_en_i, t2_cmpa_out_en_i} = 13'h1fff;
        for (int i = 0; i < 6; i++) begin
            tick();
            check("pb_tmr", {portb_drive_n_o[7:4], portb_value_o[7:4]},
                {4'h0, (i < 3) ? t0_cmpa_out_i : t1_cmpc_out_i, t1_cmpb_out_i, t1_cmpa_out_i, t2_cmpa_out_i});
            @(negedge core_clk_i);
            t0_cmpa_out_en_i = (i < 2);
        end
        {portb_dir_i, portb_pin_i, pinchg_mask_i, pinchg_group0_en_i} = {16'h003c, 8'h5a, 1'b1};
        tick();
        check("pb_nodrv", {portb_drive_n_o[7:4], 4'h0}, 8'hf0);
        check("pcint", portb_inbuf_en_o, 8'h5a);
        check("pcsrc", pinchg_src_o, 8'h3c);
        for (int m = 0; m < 2; m++) begin
            @(negedge core_clk_i);
            {portb_dir_i, portb_out_i, spi_on_i, spi_master_sel_i} = {16'hffff, 1'b1, m[0]};
            portb_pin_i = m ? 8'h59 : 8'ha6;
            tick();
            check("spi_dir", {portb_drive_n_o[3:0], portb_pullup_o[3:0]}, m ? 8'h88 : 8'h77);
            if (m) check("spi_m", {portb_value_o[2:1], spi_master_in_o, spi_slave_active_o, 4'h0},
                {spi_master_out_i, spi_sck_out_i, 6'h20});
            else check("spi_s", {portb_value_o[3], spi_slave_in_o, spi_sck_in_o, spi_slave_active_o, 4'h0},
                {spi_slave_out_i, 7'h70});
        end
        for (int x = 0; x < 9; x++) begin
            @(negedge core_clk_i);
            {extmem_on_i, extmem_high_mask_i, portc_out_i, extmem_addr_high_i, pullup_global_off_i} =
                {x < 8, x[2:0], 16'hff3c, x == 8};
            inbuf_default_i = x[0];
            tick();
            for (int i = 0; i < 8; i++) tk[i] = (x < 8) && (x < ((i > 1) ? 8 - i : 7));
            check("pc_inbuf", portc_inbuf_en_o, {8{x[0]}});
            check("pc_drv", portc_drive_n_o, ~tk);
            check("pc_pull", portc_pullup_o, (x < 8) ? ~tk : 8'h00);
            check("pc_addr", portc_value_o & tk, 8'h3c & tk);
        end
        @(negedge core_clk_i);
        {portd_out_i, usart1_tx_en_i, usart1_rx_en_i, twi_on_i, ext_irq_en_i, usart1_sync_mode_i, pullup_global_off_i} =
            {8'hff, 3'h7, 4'hf, 2'b10};
        for (int k = 0; k < 2; k++) begin
            {portd_dir_i, twi_sda_pull_low_i, portd_pin_i} = k ? {8'hff, 1'b0, 8'h2b} : {8'h00, 1'b1, 8'hd6};
            tick();
            check("pd_dir", {portd_drive_n_o[3:0], portd_pullup_o[3:0]}, k ? 8'h66 : 8'h57);
            check("pd_val", {portd_value_o[3], portd_value_o[1], portd_inbuf_en_o[3:0], 2'h0}, {usart1_tx_i, 7'h3c});
            check("pd_feed", {t0_ext_clk_in_o, t1_ext_clk_in_o, t1_capture_in_o, usart1_rx_o, ext_irq_o},
                {portd_pin_i[7:6], portd_pin_i[4], portd_pin_i[2], portd_pin_i[3:0]});
            check("pd_xck", {6'h0, k ? portd_value_o[5] : 1'b0, usart1_xclk_in_o},
                {6'h0, k ? usart1_xclk_out_i : 1'b0, portd_pin_i[5]});
            @(negedge core_clk_i);
        end
        portd_pin_i[1] = 1'b0;
        repeat (2) @(negedge core_clk_i);
        portd_pin_i[1] = 1'b1;
        repeat (6) tick();
        check("sda_spike", {7'h0, twi_sda_in_o}, 8'h01);
        @(negedge core_clk_i);
        portd_pin_i[1] = 1'b0;
        repeat (6) tick();
        check("sda_low", {7'h0, twi_sda_in_o}, 8'h00);
        complete_run();
    end
endmodule : port_bcd_alt_function_override_tb_top
